// file: verilog/aux_relay_function_controller.sv
// Auxiliary relay controller: function select, alarm, trouble, smoke reset, battery saver
//
// Behaviour
// - functions 1 and 4 energise the relay on alarm of an assigned zone.
// - function 1 holds until timeout expiry or disarm, whichever first.
// - function 4 latches; only the relay-release sequence frees it, not disarm.
// - reset gives function 1, zones 1-8 assigned, no timeout.
// - function 1 only: optional brief pulse for arming and for chime.
// - function 0 energises on zone trouble, system trouble or fire supervisory.
// - function 0 releases only after faults clear and a disarm follows.
// - function 2: second disarm after fire alarm gives six-second relay pulse.
// - function 3: relay on normally, off after four hours mains loss.
// - function 3: relay back on a few seconds after mains returns.
// - zones 1-2 of type 9 or 16 lose power on second disarm.
//
// Implementation choices: the register addresses and the address-and-strobe port.
`include "aux_relay_regs.svh"

module aux_relay_function_controller #(
  parameter int MAINS_LOSS_SECS = `MAINS_LOSS_HOURS
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdData,
  input wire logic secTick,
  input wire logic [7:0] zoneAlarm,
  input wire logic fireAlarm,
  input wire logic zoneTrouble,
  input wire logic sysTrouble,
  input wire logic fireSupervisory,
  input wire logic disarmEntry,
  input wire logic relayReleaseEntry,
  input wire logic armEvent,
  input wire logic chimeEvent,
  input wire logic mainsPresentPin,
  output logic relayOn,
  output logic [1:0] zonePowerCut
);

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers

  logic [2:0] funcSel_r;
  logic armDingEn_r;
  logic chimeEn_r;
  logic [7:0] zoneMask_r;
  logic [15:0] timeoutSecs_r;
  logic [4:0] zone1Type_r;
  logic [4:0] zone2Type_r;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      funcSel_r <= `RST_FUNC;
      armDingEn_r <= 1'b0;
      chimeEn_r <= 1'b0;
      zoneMask_r <= `RST_ZONES;
      timeoutSecs_r <= `RST_TIMEOUT;
      zone1Type_r <= `RST_ZTYPE;
      zone2Type_r <= `RST_ZTYPE;
    end else if (regWr) begin
      case (regAddr)
        `OFS_CTRL: begin
          funcSel_r <= regWrData[`CTRL_FUNC_MSB:`CTRL_FUNC_LSB];
          armDingEn_r <= regWrData[`CTRL_ARMDING_BIT];
          chimeEn_r <= regWrData[`CTRL_CHIME_BIT];
        end
        `OFS_ZONES: begin
          zoneMask_r <= regWrData[7:0];
        end
        `OFS_TIMEOUT: begin
          timeoutSecs_r <= regWrData[15:0];
        end
        `OFS_ZTYPE: begin
          zone1Type_r <= regWrData[`ZTYPE_Z1_MSB:`ZTYPE_Z1_LSB];
          zone2Type_r <= regWrData[`ZTYPE_Z2_MSB:`ZTYPE_Z2_LSB];
        end
        default: begin
        end
      endcase
    end
  end

  logic isTrouble;
  logic isTimed;
  logic isSmoke;
  logic isBatt;
  logic isLatched;

  assign isTrouble = (funcSel_r == aux_relay_pkg::FN_TROUBLE);
  assign isTimed = (funcSel_r == aux_relay_pkg::FN_ALARM_TIMED);
  assign isSmoke = (funcSel_r == aux_relay_pkg::FN_SMOKE_RESET);
  assign isBatt = (funcSel_r == aux_relay_pkg::FN_BATT_SAVER);
  assign isLatched = (funcSel_r == aux_relay_pkg::FN_ALARM_LATCHED);

  ////////////////////////////////////////////////////////////////////////////
  // Alarm activation, timed and latched

  logic [7:0] zoneAlarmPrev_r;
  logic alarmEvent;
  logic alarmActive_r;
  logic [15:0] alarmSecs_r;
  logic timeoutHit;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      zoneAlarmPrev_r <= 8'h00;
    end else begin
      zoneAlarmPrev_r <= zoneAlarm;
    end
  end

  // New alarm on any assigned zone
  assign alarmEvent = |(zoneAlarm & ~zoneAlarmPrev_r & zoneMask_r);
  // Zero timeout holds the relay until disarm
  assign timeoutHit = (timeoutSecs_r != 16'h0000) && (alarmSecs_r >= timeoutSecs_r);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      alarmActive_r <= 1'b0;
    end else if (!(isTimed || isLatched)) begin
      alarmActive_r <= 1'b0;
    end else if (alarmEvent) begin
      alarmActive_r <= 1'b1;
    end else if (isTimed && (disarmEntry || timeoutHit)) begin
      alarmActive_r <= 1'b0;
    end else if (isLatched && relayReleaseEntry) begin
      alarmActive_r <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      alarmSecs_r <= 16'h0000;
    end else if (alarmEvent || !alarmActive_r) begin
      alarmSecs_r <= 16'h0000;
    // Count stops at a nonzero limit; with zero timeout it keeps counting and wraps
    end else if (secTick && !timeoutHit) begin
      alarmSecs_r <= alarmSecs_r + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Brief pulses for arming confirmation and chime

  logic briefStart;
  logic briefActive;

  assign briefStart = isTimed && ((armEvent && armDingEn_r) || (chimeEvent && chimeEn_r));

  aux_tick_pulse briefPulse (
    .ref_clk(ref_clk),
    .rst(rst),
    .secTick(secTick),
    .start(briefStart),
    .lengthSecs(`BRIEF_PULSE_SECS),
    .active(briefActive)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Trouble and supervisory activation

  logic faultNow;
  logic troubleLatch_r;

  assign faultNow = zoneTrouble || sysTrouble || fireSupervisory;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      troubleLatch_r <= 1'b0;
    end else if (!isTrouble) begin
      troubleLatch_r <= 1'b0;
    end else if (faultNow) begin
      troubleLatch_r <= 1'b1;
    end else if (disarmEntry) begin
      troubleLatch_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Smoke detector reset after a fire alarm

  logic fireSeen_r;
  logic disarmOnce_r;
  logic smokeStart;
  logic smokeActive;

  // Second disarm following a fire alarm starts the power interrupt
  assign smokeStart = fireSeen_r && disarmOnce_r && disarmEntry && !fireAlarm;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      fireSeen_r <= 1'b0;
      disarmOnce_r <= 1'b0;
    end else if (fireAlarm) begin
      fireSeen_r <= 1'b1;
      disarmOnce_r <= 1'b0;
    end else if (smokeStart) begin
      fireSeen_r <= 1'b0;
      disarmOnce_r <= 1'b0;
    end else if (fireSeen_r && disarmEntry) begin
      disarmOnce_r <= 1'b1;
    end
  end

  aux_tick_pulse smokePulse (
    .ref_clk(ref_clk),
    .rst(rst),
    .secTick(secTick),
    .start(smokeStart),
    .lengthSecs(`SMOKE_RESET_SECS),
    .active(smokeActive)
  );

  logic zone1Fire;
  logic zone2Fire;

  assign zone1Fire = (zone1Type_r == `ZTYPE_FIRE_A) || (zone1Type_r == `ZTYPE_FIRE_B);
  assign zone2Fire = (zone2Type_r == `ZTYPE_FIRE_A) || (zone2Type_r == `ZTYPE_FIRE_B);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      zonePowerCut <= 2'b00;
    end else begin
      // Zone power follows the pulse in every function
      zonePowerCut <= {smokeActive && zone2Fire, smokeActive && zone1Fire};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Battery saver: shed load after long mains loss

  localparam logic [15:0] LOSS_SECS = 16'(MAINS_LOSS_SECS);

  logic mainsPresent;
  aux_relay_pkg::batt_state_t battState_r;
  logic [15:0] lossSecs_r;
  logic [7:0] restoreSecs_r;

  aux_level_sync #(
    .RESET_LEVEL(1'b1)
  ) mainsSync (
    .ref_clk(ref_clk),
    .rst(rst),
    .pinIn(mainsPresentPin),
    .levelOut(mainsPresent)
  );

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      lossSecs_r <= 16'h0000;
    end else if (mainsPresent) begin
      lossSecs_r <= 16'h0000;
    end else if (secTick && lossSecs_r < LOSS_SECS) begin
      lossSecs_r <= lossSecs_r + 16'h0001;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      battState_r <= aux_relay_pkg::BS_POWERED;
      restoreSecs_r <= 8'h00;
    end else begin
      case (battState_r)
        aux_relay_pkg::BS_POWERED: begin
          if (!mainsPresent && lossSecs_r >= LOSS_SECS) begin
            battState_r <= aux_relay_pkg::BS_SHED;
          end
        end
        aux_relay_pkg::BS_SHED: begin
          if (mainsPresent) begin
            battState_r <= aux_relay_pkg::BS_RESTORE;
            restoreSecs_r <= 8'h00;
          end
        end
        // Mains must stay back a few ticks before the load returns
        aux_relay_pkg::BS_RESTORE: begin
          if (!mainsPresent) begin
            battState_r <= aux_relay_pkg::BS_SHED;
          end else if (restoreSecs_r >= `MAINS_RESTORE_SECS) begin
            battState_r <= aux_relay_pkg::BS_POWERED;
          end else if (secTick) begin
            restoreSecs_r <= restoreSecs_r + 8'h01;
          end
        end
        default: begin
          battState_r <= aux_relay_pkg::BS_POWERED;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Relay drive

  logic relayNxt;

  always_comb begin
    case (funcSel_r)
      aux_relay_pkg::FN_TROUBLE: relayNxt = troubleLatch_r;
      aux_relay_pkg::FN_ALARM_TIMED: relayNxt = alarmActive_r || briefActive;
      aux_relay_pkg::FN_SMOKE_RESET: relayNxt = smokeActive;
      aux_relay_pkg::FN_BATT_SAVER: relayNxt = (battState_r == aux_relay_pkg::BS_POWERED);
      aux_relay_pkg::FN_ALARM_LATCHED: relayNxt = alarmActive_r;
      // Functions 5 to 7 leave the relay off
      default: relayNxt = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      relayOn <= 1'b0;
    end else begin
      relayOn <= relayNxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register read port

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      regRdData <= 32'h00000000;
    end else if (regRd) begin
      case (regAddr)
        `OFS_CTRL: regRdData <= {27'h0000000, chimeEn_r, armDingEn_r, funcSel_r};
        `OFS_ZONES: regRdData <= {24'h000000, zoneMask_r};
        `OFS_TIMEOUT: regRdData <= {16'h0000, timeoutSecs_r};
        `OFS_ZTYPE: regRdData <= {19'h00000, zone2Type_r, 3'h0, zone1Type_r};
        // Status is read only; writes to it fall into the default branch
        `OFS_STATUS: regRdData <= {24'h000000, zonePowerCut, smokeActive,
          battState_r == aux_relay_pkg::BS_SHED, mainsPresent, troubleLatch_r, alarmActive_r, relayOn};
        default: regRdData <= 32'h00000000;
      endcase
    end else begin
      regRdData <= 32'h00000000;
    end
  end

endmodule

// file: verilog/aux_relay_regs.svh
// Register offsets, field positions, reset values and timing counts of the auxiliary relay
`ifndef AUX_RELAY_REGS_SVH
`define AUX_RELAY_REGS_SVH

`define OFS_CTRL 8'h00
`define OFS_ZONES 8'h04
`define OFS_TIMEOUT 8'h08
`define OFS_ZTYPE 8'h0c
`define OFS_STATUS 8'h10

`define CTRL_FUNC_LSB 0
`define CTRL_FUNC_MSB 2
`define CTRL_ARMDING_BIT 3
`define CTRL_CHIME_BIT 4
`define ZTYPE_Z1_LSB 0
`define ZTYPE_Z1_MSB 4
`define ZTYPE_Z2_LSB 8
`define ZTYPE_Z2_MSB 12

`define RST_FUNC 3'h1
`define RST_ZONES 8'hff
`define RST_TIMEOUT 16'h0000
`define RST_ZTYPE 5'h00

`define ZTYPE_FIRE_A 5'h09
`define ZTYPE_FIRE_B 5'h10

`define SMOKE_RESET_SECS 8'h06
`define BRIEF_PULSE_SECS 8'h01
`define MAINS_RESTORE_SECS 8'h02
`define MAINS_LOSS_HOURS 14400

`endif

// file: verilog/aux_relay_pkg.sv
// Types shared by the auxiliary relay controller
package aux_relay_pkg;
  typedef enum logic [2:0] {
    FN_TROUBLE = 3'b000,
    FN_ALARM_TIMED = 3'b001,
    FN_SMOKE_RESET = 3'b010,
    FN_BATT_SAVER = 3'b011,
    FN_ALARM_LATCHED = 3'b100
  } relay_func_t;

  typedef enum logic [1:0] {
    BS_POWERED = 2'b00,
    BS_SHED = 2'b01,
    BS_RESTORE = 2'b10
  } batt_state_t;
endpackage

// file: verilog/aux_level_sync.sv
// Three-stage synchroniser that accepts a change once the last two stages agree
module aux_level_sync #(
  parameter logic RESET_LEVEL = 1'b0
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic pinIn,
  output logic levelOut
);
  logic stage1_r;
  logic stage2_r;
  logic stage3_r;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      stage1_r <= RESET_LEVEL;
      stage2_r <= RESET_LEVEL;
      stage3_r <= RESET_LEVEL;
    end else begin
      stage1_r <= pinIn;
      stage2_r <= stage1_r;
      stage3_r <= stage2_r;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      levelOut <= RESET_LEVEL;
    end else if (stage2_r == stage3_r) begin
      levelOut <= stage3_r;
    end
  end
endmodule

// file: verilog/aux_tick_pulse.sv
// Retriggerable pulse that lasts a given number of one-second ticks
module aux_tick_pulse (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic secTick,
  input wire logic start,
  input wire logic [7:0] lengthSecs,
  output logic active
);
  logic [7:0] remain_r;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      remain_r <= 8'h00;
    end else if (start) begin
      remain_r <= lengthSecs;
    end else if (secTick && remain_r != 8'h00) begin
      remain_r <= remain_r - 8'h01;
    end
  end

  assign active = (remain_r != 8'h00);
endmodule

// file: tb/aux_relay_monitor.sv
// Port-level checks of the auxiliary relay controller
`include "aux_relay_regs.svh"
module aux_relay_monitor #(
  parameter int MAINS_LOSS_SECS = `MAINS_LOSS_HOURS
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [31:0] regRdData,
  input wire logic secTick,
  input wire logic [7:0] zoneAlarm,
  input wire logic fireAlarm,
  input wire logic zoneTrouble,
  input wire logic sysTrouble,
  input wire logic fireSupervisory,
  input wire logic disarmEntry,
  input wire logic relayReleaseEntry,
  input wire logic armEvent,
  input wire logic chimeEvent,
  input wire logic mainsPresentPin,
  input wire logic relayOn,
  input wire logic [1:0] zonePowerCut
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////
  logic [4:0] ctrlR;
  logic [7:0] zonesR;
  logic [7:0] zPrev;
  int lossTicks;
  int cutTicks;
  wire fault = zoneTrouble | sysTrouble | fireSupervisory;
  wire alarmEv = |(zoneAlarm & ~zPrev & zonesR);
  wire f0 = ctrlR[2:0] == 3'h0;
  wire f1 = ctrlR[2:0] == 3'h1;
  wire f3 = ctrlR[2:0] == 3'h3;
  wire f4 = ctrlR[2:0] == 3'h4;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ctrlR <= 5'h01;
      zonesR <= 8'hff;
    end else if (regWr && regAddr == `OFS_CTRL) begin
      ctrlR <= regWrData[4:0];
    end else if (regWr && regAddr == `OFS_ZONES) begin
      zonesR <= regWrData[7:0];
    end
  end
  // Mains loss counted only once the pin has settled low
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      zPrev <= 8'h00;
      lossTicks <= 0;
      cutTicks <= 0;
    end else begin
      zPrev <= zoneAlarm;
      if (mainsPresentPin) lossTicks <= 0;
      else if (secTick && !$past(mainsPresentPin, 4) && lossTicks < MAINS_LOSS_SECS) lossTicks <= lossTicks + 1;
      // A tick in the launch cycle already shortens the pulse
      if (zonePowerCut == 2'h0) cutTicks <= secTick ? 1 : 0;
      else if (secTick) cutTicks <= cutTicks + 1;
    end
  end
  sequence sOn2;
    ##2 relayOn;
  endsequence
  sequence sOff2;
    ##2 !relayOn;
  endsequence
  sequence sQuiet2;
    !fault ##1 !fault;
  endsequence
  AST_ALARM_ON: assert property (alarmEv && (f1 || f4) |-> sOn2) else $error("relay off after alarm");
  AST_DISARM_OFF: assert property (f1 && ctrlR[4:3] == 2'h0 && disarmEntry && !alarmEv |-> sOff2)
    else $error("relay on after disarm");
  AST_DING: assert property (f1 && ctrlR[3] && armEvent |-> sOn2) else $error("no arming pulse");
  AST_LATCH_HOLD: assert property (f4 && relayOn && !relayReleaseEntry && !$past(relayReleaseEntry) && !regWr
    |=> relayOn) else $error("latched relay dropped");
  AST_RELEASE_OFF: assert property (f4 && relayReleaseEntry && !alarmEv |-> sOff2) else $error("release ignored");
  AST_FAULT_ON: assert property (f0 && fault |-> sOn2) else $error("relay off during fault");
  AST_CLEAR0: assert property (sQuiet2 ##1 (f0 && !fault && disarmEntry) |-> sOff2) else $error("not cleared");
  AST_SMOKE_LEN: assert property ($fell(|zonePowerCut) |-> $past(cutTicks) == 6) else $error("cut length");
  AST_BATT_OFF: assert property (f3 && lossTicks == MAINS_LOSS_SECS |-> ##3 !relayOn) else $error("no shed");
  AST_BATT_ON: assert property (f3 && $rose(mainsPresentPin) |-> ##[1:1000] relayOn) else $error("no restore");
  AST_RD_CTRL: assert property (regRd && regAddr == `OFS_CTRL |=> regRdData == {27'h0, ctrlR})
    else $error("control readback");
endmodule
bind aux_relay_function_controller aux_relay_monitor #(.MAINS_LOSS_SECS(MAINS_LOSS_SECS)) mon (
  .ref_clk, .rst, .regAddr, .regWrData, .regWr, .regRd, .regRdData, .secTick, .zoneAlarm,
  .fireAlarm, .zoneTrouble, .sysTrouble, .fireSupervisory, .disarmEntry, .relayReleaseEntry,
  .armEvent, .chimeEvent, .mainsPresentPin, .relayOn, .zonePowerCut
);

// file: tb/panel_model.sv
// Panel timebase and keypad entries
module panel_model (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [3:0] keyReq,
  output logic secTick,
  output logic disarmEntry,
  output logic relayReleaseEntry,
  output logic armEvent,
  output logic chimeEvent
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt;
  // Short tick period keeps the run brief
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt <= 0;
      secTick <= 1'b0;
    end else begin
      cnt <= (cnt == 9) ? 0 : cnt + 1;
      secTick <= cnt == 9;
    end
  end
  // Keypad entries as one-cycle pulses: bit 0 disarm, 1 release, 2 arm, 3 chime
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      {chimeEvent, armEvent, relayReleaseEntry, disarmEntry} <= 4'h0;
    end else begin
      {chimeEvent, armEvent, relayReleaseEntry, disarmEntry} <= keyReq;
    end
  end
endmodule

// file: tb/aux_relay_function_controller_tb.sv
// Self-checking bench of the auxiliary relay controller
`include "aux_relay_regs.svh"
module aux_relay_function_controller_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk;
  logic rst;
  logic [7:0] regAddr;
  logic [31:0] regWrData;
  logic regWr;
  logic regRd;
  logic [31:0] regRdData;
  logic secTick;
  logic [7:0] zoneAlarm;
  logic fireAlarm;
  logic zoneTrouble;
  logic sysTrouble;
  logic fireSupervisory;
  logic disarmEntry;
  logic relayReleaseEntry;
  logic armEvent;
  logic chimeEvent;
  logic [3:0] keyReq;
  logic mainsPresentPin;
  logic relayOn;
  logic [1:0] zonePowerCut;
  int checks = 0;
  int miscompares = 0;
  panel_model kp (
    .ref_clk, .rst, .keyReq, .secTick, .disarmEntry, .relayReleaseEntry, .armEvent, .chimeEvent
  );
  aux_relay_function_controller #(.MAINS_LOSS_SECS(5)) dut (
    .ref_clk, .rst, .regAddr, .regWrData, .regWr, .regRd, .regRdData, .secTick, .zoneAlarm,
    .fireAlarm, .zoneTrouble, .sysTrouble, .fireSupervisory, .disarmEntry, .relayReleaseEntry,
    .armEvent, .chimeEvent, .mainsPresentPin, .relayOn, .zonePowerCut
  );
  ////////////////////////////////////////
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // One keypad request cycle; the panel model turns it into an entry pulse
  task automatic press(input int k);
    @(posedge ref_clk);
    keyReq <= 4'(1 << k);
    @(posedge ref_clk);
    keyReq <= 4'h0;
  endtask
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic rel(input logic v);
    #1;
    chk("relayOn", {31'h0, relayOn}, {31'h0, v});
  endtask
  task automatic finish_test();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic waitRel(input logic v, input int n);
    int i;
    for (i = 0; i < n && relayOn !== v; i++) begin
      @(posedge ref_clk);
      #1;
    end
    chk("relayOn", {31'h0, relayOn}, {31'h0, v});
    if (relayOn !== v) finish_test();
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge ref_clk);
    regWr <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    @(posedge ref_clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge ref_clk);
    regRd <= 1'b0;
    #1;
    chk("regRdData", regRdData, e);
  endtask
  task automatic done(input string n);
    $display("test %s done", n);
  endtask
  ////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  initial begin
    rst = 1'b1;
    regAddr = 8'h00;
    regWrData = 32'h0;
    regWr = 1'b0;
    regRd = 1'b0;
    zoneAlarm = 8'h00;
    fireAlarm = 1'b0;
    {fireSupervisory, sysTrouble, zoneTrouble} = 3'h0;
    keyReq = 4'h0;
    mainsPresentPin = 1'b1;
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    rdc(`OFS_CTRL, 32'h1);
    rdc(`OFS_ZONES, 32'hff);
    rdc(`OFS_TIMEOUT, 32'h0);
    wr(8'h14, 32'hffffffff);
    rdc(8'h14, 32'h0);
    done("reset");
    zoneAlarm <= 8'h80;
    cyc(3);
    rel(1'b1);
    zoneAlarm <= 8'h00;
    cyc(40);
    rel(1'b1);
    press(0);
    cyc(2);
    rel(1'b0);
    wr(`OFS_TIMEOUT, 32'h4);
    zoneAlarm <= 8'h01;
    cyc(30);
    zoneAlarm <= 8'h03;
    cyc(25);
    rel(1'b1);
    waitRel(1'b0, 30);
    zoneAlarm <= 8'h00;
    done("alarm");
    for (int k = 2; k < 4; k++) begin
      wr(`OFS_CTRL, 32'(1 << (k + 1)) | 32'h1);
      press(k);
      waitRel(1'b1, 4);
      waitRel(1'b0, 14);
    end
    wr(`OFS_CTRL, 32'h0c);
    press(2);
    cyc(3);
    rel(1'b0);
    done("pulse");
    wr(`OFS_CTRL, 32'h04);
    zoneAlarm <= 8'h04;
    cyc(3);
    rel(1'b1);
    zoneAlarm <= 8'h00;
    press(0);
    cyc(3);
    rel(1'b1);
    press(1);
    cyc(2);
    rel(1'b0);
    done("latch");
    wr(`OFS_CTRL, 32'h0);
    for (int i = 0; i < 3; i++) begin
      {fireSupervisory, sysTrouble, zoneTrouble} <= 3'(1 << i);
      cyc(3);
      rel(1'b1);
      press(0);
      cyc(2);
      rel(1'b1);
      {fireSupervisory, sysTrouble, zoneTrouble} <= 3'h0;
      cyc(3);
      press(0);
      cyc(2);
      rel(1'b0);
    end
    done("trouble");
    wr(`OFS_ZTYPE, 32'h1009);
    wr(`OFS_CTRL, 32'h2);
    fireAlarm <= 1'b1;
    cyc(2);
    fireAlarm <= 1'b0;
    cyc(2);
    press(0);
    cyc(3);
    rel(1'b0);
    press(0);
    cyc(3);
    rel(1'b1);
    chk("zonePowerCut", {30'h0, zonePowerCut}, 32'h3);
    cyc(45);
    rel(1'b1);
    waitRel(1'b0, 20);
    chk("zonePowerCut", {30'h0, zonePowerCut}, 32'h0);
    done("smoke");
    wr(`OFS_CTRL, 32'h3);
    waitRel(1'b1, 4);
    mainsPresentPin <= 1'b0;
    cyc(30);
    rel(1'b1);
    waitRel(1'b0, 40);
    rdc(`OFS_STATUS, 32'h10);
    mainsPresentPin <= 1'b1;
    waitRel(1'b1, 40);
    done("saver");
    finish_test();
  end
endmodule
